//--- shared/psr_pkg.sv
/*
  constants, register offsets and save-area field widths for the profiling state restore block.
  assumes a 32-bit AXI4-Lite register bus and 32-bit linear addresses.
*/
package psr_pkg;
  localparam int NUM_EVT = 6;
  // event record size and implementation minimum ring size, in bytes
  localparam logic [31:0] REC_SIZE = 32'h0000_0020;
  localparam logic [31:0] MIN_BUF_SIZE = 32'h0000_0080;
  localparam logic [31:0] CB_SIZE = 32'h0000_0040;
  localparam logic [1:0] CPL_USER = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control register bit positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE64 = 1;
  localparam int CTRL_FEAT = 2;
  localparam int CTRL_OPBIT = 3;
  localparam int CTRL_SVBIT = 4;
  localparam int CTRL_CPL = 5;
  // byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DS_BASE = 8'h04;
  localparam logic [7:0] OFF_DS_LIMIT = 8'h08;
  localparam logic [7:0] OFF_DS_RO = 8'h0c;
  localparam logic [7:0] OFF_AVAIL = 8'h10;
  localparam logic [7:0] OFF_S_CB = 8'h14;
  localparam logic [7:0] OFF_S_HEAD = 8'h18;
  localparam logic [7:0] OFF_S_FLAGS = 8'h1c;
  localparam logic [7:0] OFF_S_BASE = 8'h20;
  localparam logic [7:0] OFF_S_SIZE = 8'h24;
  localparam logic [7:0] OFF_S_EVID = 8'h28;
  localparam logic [7:0] OFF_S_RDAT = 8'h2c;
  localparam logic [7:0] OFF_S_CNT = 8'h30;
  localparam logic [7:0] OFF_L_CB = 8'h50;
  localparam logic [7:0] OFF_L_BASE = 8'h54;
  localparam logic [7:0] OFF_L_SIZE = 8'h58;
  localparam logic [7:0] OFF_L_HEAD = 8'h5c;
  localparam logic [7:0] OFF_STATUS = 8'h60;
  localparam logic [7:0] OFF_L_CNT = 8'h64;
  localparam logic [7:0] CNT_SPAN = 8'h18;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int SIZE_W = 28;
  localparam int EVID_W = 8;
endpackage

//--- verilog/psr_restore.sv
/*
  profiling state restore unit: staged save-area fields, restore sequencing,
  live counters and pending record drain, all behind an AXI4-Lite slave.
  assumes the core pulses evt_hit once per retired event and takes rec_* and
  cb_fetch as one-cycle requests; one clock, synchronous active-low reset.
*/
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
// Overview of operation
// - feature mask or operand bit clear leaves profiling state untouched.
// - enables set but saved vector bit clear loads defaults, profiling off.
// - defaults zero control block address and all other internal state.
// - ring size below minimum disables profiling and ends restore.
// - ring size and head offset rounded down to record size multiple.
// - head offset beyond size minus record size becomes zero.
// - flagged available events enabled with saved counter; others disabled.
// - nonzero pending record loaded and stored once privilege is 3.
// - foreign pending records may be dropped; they need not reach buffer.
// - restore overwrites active state without saving it.
// - restore never raises threshold interrupt; next stored record does (no threshold interrupt is implemented here).
// - unrestored state fetched from control block at next record store.
// - privilege 0 reloads addresses without any validation.
// - nonzero privilege checks low and high bytes, base-relative outside 64-bit.
// - store check fails beyond limit or on read-only segment.
// - failed address check disables profiling silently, no fault.
// - feature mask clear with saved vector bit set raises protection fault.
// - every applicable simultaneous event is counted.
// - live counters held internally, not in the memory control block.
// - no lazy switching; task-switched flag has no effect.
// - save-area layout identical on every implementation.
// - save copies live values unchecked and marks vector bit when enabled (no save path here; the save area is written over the bus).
// - clear flag bit makes corresponding event inactive on restore.
module psr_restore (
  input wire logic aclk, // core clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [5:0] evt_hit, // retired event pulses
  output logic gp_fault, // protection fault pulse
  output logic rec_valid, // ring store request pulse
  output logic [31:0] rec_addr, // ring store linear address
  output logic [7:0] rec_id, // stored event identifier
  output logic [31:0] rec_data, // stored record payload
  output logic cb_fetch // control block refresh pulse
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [6:0] ctrl;
    logic [31:0] ds_base;
    logic [31:0] ds_limit;
    logic ds_ro;
    logic [5:0] avail;
    logic [31:0] s_cb;
    logic [31:0] s_head;
    logic [5:0] s_flags;
    logic [31:0] s_base;
    logic [27:0] s_size;
    logic [7:0] s_evid;
    logic [31:0] s_rdat;
    logic [5:0][31:0] s_cnt;
    logic [31:0] cb;
    logic [31:0] base;
    logic [27:0] size;
    logic [31:0] head;
    logic [5:0] en;
    logic [5:0][31:0] cnt;
    logic pend;
    logic [7:0] pend_id;
    logic [31:0] pend_dat;
    logic refresh;
    logic chkfail;
    logic gp;
    logic rec_valid;
    logic [31:0] rec_addr;
    logic [7:0] rec_id;
    logic [31:0] rec_data;
    logic cb_fetch;
  } psr_state_t;

  psr_state_t st_reg;
  psr_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] psr_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // store-type check of lowest and highest byte against the data segment
  function automatic logic psr_check(input logic [31:0] addr, input logic [31:0] len,
                                     input logic m64, input logic [31:0] dbase,
                                     input logic [31:0] lim, input logic ro);
    logic [31:0] a;
    logic [32:0] top;
    a = m64 ? addr : addr - dbase;
    top = {1'b0, a} + {1'b0, len} - 33'h0_0000_0001;
    return !ro && (a <= lim) && (top <= {1'b0, lim});
  endfunction

  logic [31:0] size_rnd;
  logic [31:0] head_rnd;
  logic [31:0] head_ok;
  logic addr_ok;
  logic [6:0] ctrl_eff;

  assign size_rnd = {4'h0, st_reg.s_size} & ~(psr_pkg::REC_SIZE - 32'h0000_0001);
  assign head_rnd = st_reg.s_head & ~(psr_pkg::REC_SIZE - 32'h0000_0001);
  assign head_ok = (st_reg.s_head > size_rnd - psr_pkg::REC_SIZE) ? psr_pkg::RST_WORD : head_rnd;
  // the restore must see the mode, enable and privilege bits written with its own go bit
  assign ctrl_eff = (st_reg.aw_got && st_reg.w_got && {st_reg.waddr[7:2], 2'b00} == psr_pkg::OFF_CTRL) ?
                    7'(psr_merge({25'h000_0000, st_reg.ctrl}, st_reg.wdata, st_reg.wstrb) & 32'h0000_007e) :
                    st_reg.ctrl;
  assign addr_ok = (ctrl_eff[psr_pkg::CTRL_CPL +: 2] == 2'h0) ||
                   (psr_check(st_reg.s_cb, psr_pkg::CB_SIZE, ctrl_eff[psr_pkg::CTRL_MODE64],
                              st_reg.ds_base, st_reg.ds_limit, st_reg.ds_ro) &&
                    psr_check(st_reg.s_base, size_rnd, ctrl_eff[psr_pkg::CTRL_MODE64],
                              st_reg.ds_base, st_reg.ds_limit, st_reg.ds_ro));

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [7:0] a;
    logic [31:0] rd;
    logic bad;
    logic go;
    logic [5:0] ld_en;
    a = 8'h00;
    rd = psr_pkg::RST_WORD;
    bad = 1'b0;
    go = 1'b0;
    ld_en = '0;
    st_next = st_reg;
    st_next.gp = 1'b0;
    st_next.rec_valid = 1'b0;
    st_next.cb_fetch = 1'b0;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.waddr = s_axi_awaddr[7:0];
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
      st_next.wready = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got) begin
      a = {st_reg.waddr[7:2], 2'b00};
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = psr_pkg::RESP_OKAY;
      if (a == psr_pkg::OFF_CTRL) begin
        st_next.ctrl = ctrl_eff;
        go = st_reg.wstrb[0] && st_reg.wdata[psr_pkg::CTRL_GO];
      end else if (a == psr_pkg::OFF_DS_BASE) begin
        st_next.ds_base = psr_merge(st_reg.ds_base, st_reg.wdata, st_reg.wstrb);
      end else if (a == psr_pkg::OFF_DS_LIMIT) begin
        st_next.ds_limit = psr_merge(st_reg.ds_limit, st_reg.wdata, st_reg.wstrb);
      end else if (a == psr_pkg::OFF_DS_RO) begin
        st_next.ds_ro = st_reg.wstrb[0] ? st_reg.wdata[0] : st_reg.ds_ro;
      end else if (a == psr_pkg::OFF_AVAIL) begin
        st_next.avail = st_reg.wstrb[0] ? st_reg.wdata[6:1] : st_reg.avail;
      end else if (a == psr_pkg::OFF_S_CB) begin
        st_next.s_cb = psr_merge(st_reg.s_cb, st_reg.wdata, st_reg.wstrb);
      end else if (a == psr_pkg::OFF_S_HEAD) begin
        st_next.s_head = psr_merge(st_reg.s_head, st_reg.wdata, st_reg.wstrb);
      end else if (a == psr_pkg::OFF_S_FLAGS) begin
        st_next.s_flags = st_reg.wstrb[0] ? st_reg.wdata[6:1] : st_reg.s_flags;
      end else if (a == psr_pkg::OFF_S_BASE) begin
        st_next.s_base = psr_merge(st_reg.s_base, st_reg.wdata, st_reg.wstrb);
      end else if (a == psr_pkg::OFF_S_SIZE) begin
        st_next.s_size = 28'(psr_merge({4'h0, st_reg.s_size}, st_reg.wdata, st_reg.wstrb));
      end else if (a == psr_pkg::OFF_S_EVID) begin
        st_next.s_evid = st_reg.wstrb[0] ? st_reg.wdata[7:0] : st_reg.s_evid;
      end else if (a == psr_pkg::OFF_S_RDAT) begin
        st_next.s_rdat = psr_merge(st_reg.s_rdat, st_reg.wdata, st_reg.wstrb);
      end else if (a >= psr_pkg::OFF_S_CNT && a < psr_pkg::OFF_S_CNT + psr_pkg::CNT_SPAN) begin
        st_next.s_cnt[3'((a - psr_pkg::OFF_S_CNT) >> 2)] =
          psr_merge(st_reg.s_cnt[3'((a - psr_pkg::OFF_S_CNT) >> 2)], st_reg.wdata, st_reg.wstrb);
      end else begin
        st_next.bresp = psr_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready = !st_next.w_got && !st_next.bvalid;

    // read channel
    if (s_axi_arvalid && st_reg.arready) begin
      a = {s_axi_araddr[7:2], 2'b00};
      if (a == psr_pkg::OFF_CTRL) begin
        rd = {25'h000_0000, st_reg.ctrl};
      end else if (a == psr_pkg::OFF_L_CB) begin
        rd = st_reg.cb;
      end else if (a == psr_pkg::OFF_L_BASE) begin
        rd = st_reg.base;
      end else if (a == psr_pkg::OFF_L_SIZE) begin
        rd = {4'h0, st_reg.size};
      end else if (a == psr_pkg::OFF_L_HEAD) begin
        rd = st_reg.head;
      end else if (a == psr_pkg::OFF_STATUS) begin
        rd = {21'h00_0000, st_reg.pend, st_reg.refresh, st_reg.chkfail, (st_reg.cb != 32'h0000_0000),
              st_reg.en, 1'b0};
      end else if (a >= psr_pkg::OFF_L_CNT && a < psr_pkg::OFF_L_CNT + psr_pkg::CNT_SPAN) begin
        rd = st_reg.cnt[3'((a - psr_pkg::OFF_L_CNT) >> 2)];
      end else begin
        bad = 1'b1;
      end
      st_next.rdata = rd;
      st_next.rresp = bad ? psr_pkg::RESP_SLVERR : psr_pkg::RESP_OKAY;
      st_next.rvalid = 1'b1;
      st_next.arready = 1'b0;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
    // ready whenever no data waits; reset clears it, so reads are accepted from one cycle after reset
    st_next.arready = !st_next.rvalid;

    // counting runs only when no restore happens this cycle
    // the task-switched flag is not an input: no lazy switching
    if (!go && st_reg.cb != 32'h0000_0000 && st_reg.ctrl[psr_pkg::CTRL_CPL +: 2] == psr_pkg::CPL_USER) begin
      for (int i = 0; i < psr_pkg::NUM_EVT; i++) begin
        if (st_reg.en[i] && evt_hit[i]) begin
          st_next.cnt[i] = st_reg.cnt[i] - 32'h0000_0001;
        end
      end
      // pending record drains at user privilege
      if (st_reg.pend) begin
        st_next.rec_valid = 1'b1;
        st_next.rec_addr = st_reg.base + st_reg.head;
        st_next.rec_id = st_reg.pend_id;
        st_next.rec_data = st_reg.pend_dat;
        st_next.pend = 1'b0;
        st_next.head = (st_reg.head + psr_pkg::REC_SIZE >= {4'h0, st_reg.size}) ?
                       psr_pkg::RST_WORD : st_reg.head + psr_pkg::REC_SIZE;
        // the rest of the cached state comes from memory with this store
        st_next.cb_fetch = st_reg.refresh;
        st_next.refresh = 1'b0;
      end
    end

    // restore sequencing, one step; old state overwritten unsaved
    if (go) begin
      if (!ctrl_eff[psr_pkg::CTRL_FEAT] || !ctrl_eff[psr_pkg::CTRL_OPBIT]) begin
        // state untouched
        st_next.gp = !ctrl_eff[psr_pkg::CTRL_FEAT] && ctrl_eff[psr_pkg::CTRL_SVBIT];
      end else begin
        // defaults first; threshold interrupt is never raised here
        st_next.cb = psr_pkg::RST_WORD;
        st_next.base = psr_pkg::RST_WORD;
        st_next.size = '0;
        st_next.head = psr_pkg::RST_WORD;
        st_next.en = '0;
        st_next.cnt = '0;
        st_next.pend = 1'b0;
        st_next.pend_id = '0;
        st_next.pend_dat = psr_pkg::RST_WORD;
        st_next.refresh = 1'b0;
        st_next.chkfail = 1'b0;
        if (!ctrl_eff[psr_pkg::CTRL_SVBIT] || st_reg.s_cb == 32'h0000_0000) begin
          // defaults stand
        end else if ({4'h0, st_reg.s_size} < psr_pkg::MIN_BUF_SIZE) begin
          // disabled, rest of restore skipped
        end else if (!addr_ok) begin
          st_next.chkfail = 1'b1;
        end else begin
          ld_en = st_reg.s_flags & st_reg.avail;
          st_next.cb = st_reg.s_cb;
          st_next.base = st_reg.s_base;
          st_next.size = size_rnd[27:0];
          st_next.head = head_ok;
          st_next.en = ld_en;
          for (int i = 0; i < psr_pkg::NUM_EVT; i++) begin
            st_next.cnt[i] = ld_en[i] ? st_reg.s_cnt[i] : psr_pkg::RST_WORD;
          end
          // records are taken as they come; no provenance tag is kept
          st_next.pend = st_reg.s_evid != 8'h00;
          st_next.pend_id = st_reg.s_evid;
          st_next.pend_dat = st_reg.s_rdat;
          st_next.refresh = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign gp_fault = st_reg.gp;
  assign rec_valid = st_reg.rec_valid;
  assign rec_addr = st_reg.rec_addr;
  assign rec_id = st_reg.rec_id;
  assign rec_data = st_reg.rec_data;
  assign cb_fetch = st_reg.cb_fetch;

  // save-area field layout is fixed by the package widths
  // supervisor must restore on every switch; nothing here compensates

endmodule

//--- testbench/psr_monitor.sv
/*
  port-level assertions for the profiling state restore block.
  assumes it is bound to psr_restore: one clock, synchronous active-low reset.
*/
module psr_monitor (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic gp_fault, // protection fault pulse
  input wire logic rec_valid, // ring store pulse
  input wire logic [31:0] rec_addr, // ring store address
  input wire logic [7:0] rec_id, // stored event id
  input wire logic [31:0] rec_data, // stored payload
  input wire logic cb_fetch // control block refresh pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_clk @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  sequence s_b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_fault_cause; $past(s_axi_bvalid) || s_axi_bvalid; endsequence
  ////////////////////////////////////////////////////////////////
  a_b_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_b_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("read data missing");
  a_b_blocks_aw: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_r_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == psr_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_fault_pulse: assert property ($rose(gp_fault) |-> s_fault_cause ##1 !gp_fault)
    else $error("fault pulse without restore write");
  a_rec_id_set: assert property (rec_valid |-> rec_id != 8'h00)
    else $error("record stored with empty id");
  a_fetch_on_rec: assert property (cb_fetch |-> rec_valid)
    else $error("control block fetch without record store");
  a_rec_held: assert property (!rec_valid |-> $stable(rec_addr) && $stable(rec_id) && $stable(rec_data))
    else $error("record outputs moved without store");
endmodule

bind psr_restore psr_monitor u_mon (.*);

//--- testbench/testbench.sv
/*
  self-checking bench for the profiling state restore block, one task per scenario.
  assumes psr_pkg and psr_restore are compiled first; register bus is AXI4-Lite.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic [5:0] evt_hit = 6'h0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rec_addr, rec_data;
  logic [7:0] rec_id;
  logic awready, wready, bvalid, arready, rvalid, gp_fault, rec_valid, cb_fetch;
  int n_errors = 0, total_checks = 0, gp_n = 0, rec_n = 0, cf_n = 0;
  always #10 aclk = ~aclk;
  psr_restore dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt_hit(evt_hit),
    .gp_fault(gp_fault), .rec_valid(rec_valid), .rec_addr(rec_addr), .rec_id(rec_id),
    .rec_data(rec_data), .cb_fetch(cb_fetch));
  always @(posedge aclk) begin
    if (gp_fault === 1'b1) gp_n++;
    if (rec_valid === 1'b1) rec_n++;
    if (cb_fetch === 1'b1) cf_n++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = psr_pkg::RESP_OKAY,
                    input int hold = 0);
    int n;
    n = 0;
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    if (hold > 0) bready <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n >= hold && !bready) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready) && n < 50);
    if (n >= 50) begin n_errors++; stop_test(); end
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = psr_pkg::RESP_OKAY,
                    input logic [31:0] m = 32'hffff_ffff, input int hold = 0);
    int n;
    n = 0;
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    if (hold > 0) rready <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n >= hold && !rready) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready) && n < 50);
    if (n >= 50) begin n_errors++; stop_test(); end
    chk(rdata & m, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // every switch stages a save area, then restores it through the control word
  task automatic rs(input logic [31:0] ctl, input logic [31:0] cb = 32'h0000_1000,
                    input logic [31:0] bs = 32'h0000_2000, input logic [31:0] sz = 32'h0000_0100,
                    input logic [31:0] hd = 32'h0000_0000, input logic [31:0] fl = 32'h0000_0000,
                    input logic [31:0] ev = 32'h0000_0000);
    wr(psr_pkg::OFF_S_CB, cb);
    wr(psr_pkg::OFF_S_BASE, bs);
    wr(psr_pkg::OFF_S_SIZE, sz);
    wr(psr_pkg::OFF_S_HEAD, hd);
    wr(psr_pkg::OFF_S_FLAGS, fl);
    wr(psr_pkg::OFF_S_EVID, ev);
    wr(psr_pkg::OFF_CTRL, ctl);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_bus();
    rd(psr_pkg::OFF_L_CB, 32'h0000_0000, psr_pkg::RESP_OKAY, 32'hffff_ffff, 3);
    rd(psr_pkg::OFF_CTRL, 32'h0000_0000);
    wr(8'h7c, 32'h0000_1234, psr_pkg::RESP_SLVERR, 3);
    wr(psr_pkg::OFF_L_CB, 32'h0000_1234, psr_pkg::RESP_SLVERR);
    rd(psr_pkg::OFF_S_CB, 32'h0000_0000, psr_pkg::RESP_SLVERR);
    rd(8'hfc, 32'h0000_0000, psr_pkg::RESP_SLVERR);
    $display("done bus access");
  endtask
  task automatic t_load();
    wr(psr_pkg::OFF_AVAIL, 32'h0000_0066);
    wr(psr_pkg::OFF_DS_LIMIT, 32'h0000_0000);
    wr(psr_pkg::OFF_DS_RO, 32'h0000_0001);
    wr(psr_pkg::OFF_S_CNT, 32'h0000_0011);
    wr(psr_pkg::OFF_S_CNT + 8'h10, 32'h0000_0055);
    rs(32'h0000_001d, 32'h0000_1000, 32'h0000_2000, 32'h0000_0135, 32'h0000_00f5, 32'h0000_002a);
    rd(psr_pkg::OFF_L_CB, 32'h0000_1000);
    rd(psr_pkg::OFF_L_BASE, 32'h0000_2000);
    rd(psr_pkg::OFF_L_SIZE, 32'h0000_0120);
    rd(psr_pkg::OFF_L_HEAD, 32'h0000_00e0);
    rd(psr_pkg::OFF_STATUS, 32'h0000_00a2, psr_pkg::RESP_OKAY, 32'h0000_00fe);
    rd(psr_pkg::OFF_L_CNT, 32'h0000_0011);
    rd(psr_pkg::OFF_L_CNT + 8'h10, 32'h0000_0055);
    rs(32'h0000_001d, 32'h0000_1800, 32'h0000_2000, 32'h0000_0120, 32'h0000_0100);
    rd(psr_pkg::OFF_L_CB, 32'h0000_1800);
    rd(psr_pkg::OFF_L_HEAD, 32'h0000_0100);
    rs(32'h0000_001d, 32'h0000_1000, 32'h0000_2000, 32'h0000_007f);
    rd(psr_pkg::OFF_L_CB, 32'h0000_0000);
    rs(32'h0000_001d, 32'h0000_1000, 32'h0000_2000, 32'h0000_0080, 32'h0000_0061);
    rd(psr_pkg::OFF_L_SIZE, 32'h0000_0080);
    rd(psr_pkg::OFF_L_HEAD, 32'h0000_0000);
    $display("done pointer load");
  endtask
  task automatic t_gate();
    int g;
    rs(32'h0000_001d);
    g = gp_n;
    rs(32'h0000_0015, 32'h0000_3000);
    rd(psr_pkg::OFF_L_CB, 32'h0000_1000);
    rs(32'h0000_0009, 32'h0000_3000);
    rd(psr_pkg::OFF_L_CB, 32'h0000_1000);
    rs(32'h0000_0011, 32'h0000_3000);
    repeat (4) @(posedge aclk);
    chk(32'(gp_n - g), 32'h0000_0001);
    rs(32'h0000_000d, 32'h0000_3000);
    rd(psr_pkg::OFF_L_CB, 32'h0000_0000);
    rd(psr_pkg::OFF_L_SIZE, 32'h0000_0000);
    rd(psr_pkg::OFF_STATUS, 32'h0000_0000);
    $display("done enable gating");
  endtask
  task automatic t_check();
    int g;
    g = gp_n;
    wr(psr_pkg::OFF_DS_BASE, 32'h0000_1000);
    wr(psr_pkg::OFF_DS_LIMIT, 32'h0000_ffff);
    wr(psr_pkg::OFF_DS_RO, 32'h0000_0000);
    rs(32'h0000_007d, 32'h0000_1100, 32'h0000_3000);
    rd(psr_pkg::OFF_L_CB, 32'h0000_1100);
    wr(psr_pkg::OFF_DS_RO, 32'h0000_0001);
    rs(32'h0000_007d, 32'h0000_1100, 32'h0000_3000);
    rd(psr_pkg::OFF_STATUS, 32'h0000_0100, psr_pkg::RESP_OKAY, 32'h0000_0180);
    wr(psr_pkg::OFF_DS_RO, 32'h0000_0000);
    wr(psr_pkg::OFF_DS_LIMIT, 32'h0000_20fe);
    rs(32'h0000_007d, 32'h0000_1100, 32'h0000_3000);
    rd(psr_pkg::OFF_L_CB, 32'h0000_0000);
    wr(psr_pkg::OFF_DS_LIMIT, 32'h0000_20ff);
    rs(32'h0000_007d, 32'h0000_1100, 32'h0000_3000);
    rd(psr_pkg::OFF_L_CB, 32'h0000_1100);
    rs(32'h0000_007f, 32'h0000_1100, 32'h0000_3000);
    rd(psr_pkg::OFF_L_CB, 32'h0000_0000);
    chk(32'(gp_n - g), 32'h0000_0000);
    $display("done address checks");
  endtask
  task automatic t_drain();
    int r, f;
    wr(psr_pkg::OFF_DS_BASE, 32'h0000_0000);
    wr(psr_pkg::OFF_DS_LIMIT, 32'hffff_ffff);
    wr(psr_pkg::OFF_S_CNT, 32'h0000_000a);
    wr(psr_pkg::OFF_S_CNT + 8'h04, 32'h0000_0014);
    wr(psr_pkg::OFF_S_RDAT, 32'hdead_beef);
    r = rec_n;
    f = cf_n;
    rs(32'h0000_007f, 32'h0000_1000, 32'h0000_3000, 32'h0000_0100, 32'h0000_0040, 32'h0000_0006, 32'h0000_0005);
    evt_hit <= 6'h03;
    repeat (3) @(posedge aclk);
    evt_hit <= 6'h00;
    repeat (4) @(posedge aclk);
    chk(32'(rec_n - r), 32'h0000_0001);
    chk(rec_addr, 32'h0000_3040);
    chk({24'h00_0000, rec_id}, 32'h0000_0005);
    chk(rec_data, 32'hdead_beef);
    chk(32'(cf_n - f), 32'h0000_0001);
    rd(psr_pkg::OFF_L_HEAD, 32'h0000_0060);
    rd(psr_pkg::OFF_L_CNT, 32'h0000_0007);
    rd(psr_pkg::OFF_L_CNT + 8'h04, 32'h0000_0011);
    $display("done record drain");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_bus();
    t_load();
    t_gate();
    t_check();
    t_drain();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    stop_test();
  end
endmodule
